// ---- rtl/power_pins_pkg.sv ----
// Shared constants and types for the power control pin block.
package power_pins_pkg;
	// Core clock rate and derived timing.
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned ACK_TIMEOUT_S = 5;
	localparam int unsigned VIN_TIMEOUT_S = 5;
	localparam longint unsigned ACK_TIMEOUT_CYCLES = longint'(ACK_TIMEOUT_S) * CLK_HZ;
	localparam longint unsigned VIN_TIMEOUT_CYCLES = longint'(VIN_TIMEOUT_S) * CLK_HZ;
	localparam int unsigned TIMER_W = 32;
	// Serial port addresses of the two variants.
	localparam logic [6:0] SLAVE_ADDR_STD = 7'h3c;
	localparam logic [6:0] SLAVE_ADDR_TERM = 7'h3d;
	// Register offsets.
	localparam logic [7:0] OFF_RUN_VOLT = 8'h00;
	localparam logic [7:0] OFF_STBY_VOLT = 8'h01;
	localparam logic [7:0] OFF_CTRL = 8'h02;
	localparam logic [7:0] OFF_STATUS = 8'h03;
	localparam logic [7:0] OFF_IRQ_EN = 8'h04;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h05;
	localparam logic [7:0] OFF_PINS = 8'h06;
	localparam logic [7:0] OFF_ADDR = 8'h07;
	// Field positions.
	localparam int unsigned RUN_SEL_BIT = 5;
	localparam int unsigned CTRL_SLEW_MASK_BIT = 0;
	localparam int unsigned CTRL_HARD_RESET_BIT = 1;
	localparam int unsigned CTRL_REG_ENABLE_BIT = 2;
	localparam int unsigned NUM_EVENTS = 5;
	localparam int unsigned EV_POWER_OK_OUT = 0;
	localparam int unsigned EV_UV = 1;
	localparam int unsigned EV_OT = 2;
	localparam int unsigned EV_ACK_TIMEOUT = 3;
	localparam int unsigned EV_VIN_TIMEOUT = 4;
	localparam int unsigned NUM_REGS = 7;
	// Reset values.
	localparam logic [7:0] RUN_VOLT_RESET = 8'h00;
	localparam logic [7:0] STBY_VOLT_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [NUM_EVENTS-1:0] IRQ_EN_RESET = 5'h1f;
	// Idle levels of the synchronised pins; only the pushbutton at bit 9 rests high.
	localparam logic [22:0] PIN_IDLE = 23'h000200;
	// Power-up handshake states.
	typedef enum logic [3:0] {
		ST_OFF = 4'h1,
		ST_WAIT_ACK = 4'h2,
		ST_ON = 4'h4,
		ST_SHUTDOWN = 4'h8
	} wake_state_type;
endpackage

// ---- rtl/sync_bus_if.sv ----
// Interface carrying synchronised pin levels between modules.
`timescale 1ns/100ps
`default_nettype none
interface sync_bus_if;
	logic [22:0] raw;
	logic [22:0] synced;
	modport sync_side (input raw, output synced);
	modport user_side (output raw, input synced);
endinterface
`default_nettype wire

// ---- rtl/pin_sync.sv ----
// Two-stage synchroniser for all asynchronous pin inputs.
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
	// Clock and control
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Pin levels
	sync_bus_if.sync_side bus
);
	logic [22:0] stage1_reg;
	logic [22:0] stage2_reg;
	// Only the second stage is read; reset loads idle levels so no false press follows it.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			stage1_reg <= power_pins_pkg::PIN_IDLE;
			stage2_reg <= power_pins_pkg::PIN_IDLE;
		end else if (clk_en) begin
			stage1_reg <= bus.raw;
			stage2_reg <= stage1_reg;
		end
	end
	assign bus.synced = stage2_reg;
endmodule
`default_nettype wire

// ---- rtl/cycle_timer.sv ----
// Down-counting timeout timer with a one-cycle expiry pulse.
`timescale 1ns/100ps
`default_nettype none
module cycle_timer #(
	parameter logic [31:0] LOAD = 32'h3b9aca00
) (
	// Clock and control
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Timer control
	input wire logic run,
	output logic expired
);
	logic [31:0] count_reg;
	logic fired_reg;
	// Count while run is high; reload when it drops, fire once when the count reaches one.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			count_reg <= LOAD;
			fired_reg <= 1'b0;
		end else if (clk_en) begin
			if (!run) begin
				count_reg <= LOAD;
				fired_reg <= 1'b0;
			end else if (count_reg > 32'h1) begin
				count_reg <= count_reg - 32'h1;
			end else begin
				fired_reg <= 1'b1;
			end
		end
	end
	assign expired = run && (count_reg <= 32'h1) && !fired_reg && rst_n && clk_en;
endmodule
`default_nettype wire

// ---- rtl/power_pins.sv ----
// Control and status pin logic of the multi-rail power manager.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module power_pins #(
	parameter logic [31:0] ACK_TIMEOUT = 32'(power_pins_pkg::ACK_TIMEOUT_CYCLES),
	parameter logic [31:0] VIN_TIMEOUT = 32'(power_pins_pkg::VIN_TIMEOUT_CYCLES),
	parameter bit TERM_VARIANT = 1'b0
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Regulator enable pins, undriven reads low
	input wire logic ldo_a_enable_in,
	input wire logic ldo_b_enable_in,
	input wire logic ldo_c_enable_in,
	input wire logic buck_one_enable_in,
	input wire logic buck_two_enable_in,
	input wire logic buck_three_enable_in,
	input wire logic buck_four_enable_in,
	// Other control pins
	input wire logic standby_voltage_select_in,
	input wire logic power_ack_in,
	input wire logic button_n,
	// Analog monitor flags
	input wire logic [6:0] rail_below_pg,
	input wire logic any_slewing,
	input wire logic undervoltage,
	input wire logic overtemp,
	input wire logic always_alive_low,
	input wire logic vin_above_uv,
	input wire logic serial_port_supply_low,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Regulator controls
	output logic [6:0] rail_enable,
	output logic termination_reference_enable,
	output logic use_standby_voltage,
	output logic [6:0] slave_address,
	output logic power_removed,
	// Open-drain pins, output enable high means pulling low
	output logic wake_out,
	output logic wake_oe,
	output logic irq_out,
	output logic irq_oe,
	output logic reset_out,
	output logic reset_oe,
	output logic power_ok_out,
	output logic power_ok_oe,
	// Level interrupt
	output logic irq
);
	import power_pins_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisation.
	sync_bus_if sbus ();
	logic [6:0] en_pins;
	logic ack_s;
	logic button_pressed;
	logic stby_s;
	logic [6:0] below_s;
	logic slew_s;
	logic uv_s;
	logic ot_s;
	logic alive_low_s;
	logic vin_ok_s;
	logic sp_low_s;

	assign sbus.raw = {serial_port_supply_low, vin_above_uv, always_alive_low, overtemp,
		undervoltage, any_slewing, rail_below_pg, button_n, power_ack_in,
		standby_voltage_select_in, buck_four_enable_in, buck_three_enable_in,
		buck_two_enable_in, buck_one_enable_in, ldo_c_enable_in, ldo_b_enable_in,
		ldo_a_enable_in};

	pin_sync u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.bus(sbus.sync_side)
	);

	// Pull-down and pull-up are external: an undriven pin arrives as its idle level.
	assign en_pins = sbus.synced[6:0];
	assign stby_s = sbus.synced[7];
	assign ack_s = sbus.synced[8];
	assign button_pressed = !sbus.synced[9];
	assign below_s = sbus.synced[16:10];
	assign slew_s = sbus.synced[17];
	assign uv_s = sbus.synced[18];
	assign ot_s = sbus.synced[19];
	assign alive_low_s = sbus.synced[20];
	assign vin_ok_s = sbus.synced[21];
	assign sp_low_s = sbus.synced[22];

	////////////////////////////////////////////////////////////////////////////////
	// Registers; supply loss acts as a register reset.
	logic regs_reset;
	logic [7:0] run_volt_reg;
	logic [7:0] stby_volt_reg;
	logic [7:0] ctrl_reg;
	logic [NUM_EVENTS-1:0] status_reg;
	logic [NUM_EVENTS-1:0] status_next;
	logic [NUM_EVENTS-1:0] irq_en_reg;
	logic [NUM_EVENTS-1:0] events;
	logic [NUM_EVENTS-1:0] clr_mask;
	logic wr_run;
	logic wr_stby;
	logic wr_ctrl;
	logic wr_en;
	logic wr_clr;

	assign regs_reset = !rst_n || sp_low_s;
	assign wr_run = reg_wr && (reg_addr == OFF_RUN_VOLT);
	assign wr_stby = reg_wr && (reg_addr == OFF_STBY_VOLT);
	assign wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
	assign wr_en = reg_wr && (reg_addr == OFF_IRQ_EN);
	assign wr_clr = reg_wr && (reg_addr == OFF_IRQ_CLR);
	assign clr_mask = wr_clr ? reg_wdata[NUM_EVENTS-1:0] : '0;

	// Writable control registers.
	always_ff @(posedge core_clk) begin
		if (regs_reset) begin
			run_volt_reg <= RUN_VOLT_RESET;
			stby_volt_reg <= STBY_VOLT_RESET;
			ctrl_reg <= CTRL_RESET;
			irq_en_reg <= IRQ_EN_RESET;
		end else if (clk_en) begin
			if (wr_run) run_volt_reg <= reg_wdata;
			if (wr_stby) stby_volt_reg <= reg_wdata;
			if (wr_ctrl) ctrl_reg <= reg_wdata;
			if (wr_en) irq_en_reg <= reg_wdata[NUM_EVENTS-1:0];
		end
	end

	// Sticky status: a new event wins over a clear in the same cycle.
	assign status_next = (status_reg & ~clr_mask) | events;
	always_ff @(posedge core_clk) begin
		if (regs_reset) begin
			status_reg <= '0;
		end else if (clk_en) begin
			status_reg <= status_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Regulator enables and voltage selection.
	logic [6:0] enabled;
	logic all_off;
	logic pg_fail;
	logic slew_hit;

	assign enabled = en_pins | {7{ctrl_reg[CTRL_REG_ENABLE_BIT]}};
	assign rail_enable = power_removed ? 7'h0 : enabled;
	// Bit 3 of the enable group is the first buck.
	assign termination_reference_enable = TERM_VARIANT && rail_enable[3];
	// Standby pin overrides the software selection.
	assign use_standby_voltage = stby_s || run_volt_reg[RUN_SEL_BIT];
	assign slave_address = TERM_VARIANT ? SLAVE_ADDR_TERM : SLAVE_ADDR_STD;

	// Power ok: an enabled rail below threshold, an unmasked slew, or nothing enabled.
	assign all_off = (rail_enable == 7'h0);
	assign pg_fail = |(below_s & rail_enable);
	assign slew_hit = slew_s && !ctrl_reg[CTRL_SLEW_MASK_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Wake handshake and start-up timeouts.
	wake_state_type state_reg;
	wake_state_type state_next;
	logic ack_expired;
	logic vin_expired;
	logic vin_watch_reg;

	cycle_timer #(.LOAD(ACK_TIMEOUT)) u_ack_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.run(state_reg == ST_WAIT_ACK),
		.expired(ack_expired)
	);

	cycle_timer #(.LOAD(VIN_TIMEOUT)) u_vin_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.run(vin_watch_reg),
		.expired(vin_expired)
	);

	// Watch the input rise only once per power-up; crossing ends the watch.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			vin_watch_reg <= 1'b1;
		end else if (clk_en && (vin_ok_s || vin_expired)) begin
			vin_watch_reg <= 1'b0;
		end
	end

	// Handshake state machine.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_OFF: begin
				if (button_pressed || ack_s) state_next = ST_WAIT_ACK;
			end
			ST_WAIT_ACK: begin
				if (ack_s) state_next = ST_ON;
				else if (ack_expired) state_next = ST_SHUTDOWN;
			end
			ST_ON: begin
				if (!ack_s) state_next = ST_OFF;
			end
			ST_SHUTDOWN: begin
				if (button_pressed || ack_s) state_next = ST_WAIT_ACK;
			end
		endcase
		if (vin_expired) state_next = ST_SHUTDOWN;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg <= ST_OFF;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// Power is removed after a missed handshake or a stalled input rise.
	assign power_removed = (state_reg == ST_SHUTDOWN);

	////////////////////////////////////////////////////////////////////////////////
	// Events and open-drain outputs.
	logic pg_fail_reg;
	logic wake_reg;
	logic irq_pin_reg;
	logic reset_low_reg;
	logic pok_low_reg;

	assign events[EV_POWER_OK_OUT] = pg_fail && !pg_fail_reg;
	assign events[EV_UV] = uv_s;
	assign events[EV_OT] = ot_s;
	assign events[EV_ACK_TIMEOUT] = ack_expired;
	assign events[EV_VIN_TIMEOUT] = vin_expired;
	assign irq = |(status_reg & irq_en_reg);

	// Registered pin drives so the pins never glitch.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pg_fail_reg <= 1'b0;
			wake_reg <= 1'b0;
			irq_pin_reg <= 1'b0;
			reset_low_reg <= 1'b1;
			pok_low_reg <= 1'b1;
		end else if (clk_en) begin
			pg_fail_reg <= pg_fail;
			wake_reg <= (state_next == ST_WAIT_ACK) || (state_next == ST_ON);
			irq_pin_reg <= |(status_next & irq_en_reg);
			reset_low_reg <= alive_low_s || ctrl_reg[CTRL_HARD_RESET_BIT];
			pok_low_reg <= pg_fail || slew_hit || all_off;
		end
	end

	// Open-drain: output data is zero, enable pulls the pin low.
	assign wake_out = 1'b0;
	assign wake_oe = !wake_reg;
	assign irq_out = 1'b0;
	assign irq_oe = irq_pin_reg;
	assign reset_out = 1'b0;
	assign reset_oe = reset_low_reg;
	assign power_ok_out = 1'b0;
	assign power_ok_oe = pok_low_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe; unmapped addresses read zero.
	logic [7:0] rd_mux;
	assign rd_mux = (reg_addr == OFF_RUN_VOLT) ? run_volt_reg :
		(reg_addr == OFF_STBY_VOLT) ? stby_volt_reg :
		(reg_addr == OFF_CTRL) ? ctrl_reg :
		(reg_addr == OFF_STATUS) ? {3'h0, status_reg} :
		(reg_addr == OFF_IRQ_EN) ? {3'h0, irq_en_reg} :
		(reg_addr == OFF_PINS) ? {wake_reg, enabled} :
		(reg_addr == OFF_ADDR) ? {1'b0, slave_address} : 8'h00;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (clk_en) begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end
endmodule
`default_nettype wire

// ---- bench/power_pins_chk.sv ----
// Concurrent checks on the ports of the power control pin block.
`timescale 1ns/100ps
`default_nettype none
module power_pins_chk #(
	parameter logic [31:0] ACK_TIMEOUT = 32'h14,
	parameter bit TERM_VARIANT = 1'b0
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Pins and monitor flags
	input wire logic ldo_a_enable_in,
	input wire logic standby_voltage_select_in,
	input wire logic power_ack_in,
	input wire logic button_n,
	input wire logic [6:0] rail_below_pg,
	input wire logic undervoltage,
	input wire logic overtemp,
	input wire logic always_alive_low,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	// Outputs
	input wire logic [6:0] rail_enable,
	input wire logic termination_reference_enable,
	input wire logic use_standby_voltage,
	input wire logic [6:0] slave_address,
	input wire logic power_removed,
	input wire logic wake_oe,
	input wire logic irq_oe,
	input wire logic reset_oe,
	input wire logic power_ok_oe
);
	import power_pins_pkg::*;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n || !clk_en);
	logic [31:0] ack_wait_reg;
	////////////////////////////////////////////////////////////////////////////////////////////
	// Raw cycles of an unanswered wake; the margin below absorbs the pin synchroniser.
	always_ff @(posedge core_clk) begin
		if (!rst_n || wake_oe || power_ack_in || power_removed) begin
			ack_wait_reg <= 32'h0;
		end else begin
			ack_wait_reg <= ack_wait_reg + 32'h1;
		end
	end
	chk_enable_pin_on: assert property (ldo_a_enable_in [*3] ##0 !power_removed |-> rail_enable[0])
		else $error("enable pin did not turn the rail on");
	chk_standby_forced: assert property (standby_voltage_select_in [*3] |-> use_standby_voltage)
		else $error("standby pin did not force the standby set");
	chk_ack_timeout_off: assert property (ack_wait_reg == ACK_TIMEOUT + 32'h8 |-> power_removed)
		else $error("power kept without acknowledge");
	chk_ack_drop_wake: assert property ($fell(power_ack_in) |-> ##[1:4] wake_oe)
		else $error("wake not deactivated after acknowledge fell");
	chk_press_wake: assert property ($fell(button_n) |-> ##[1:4] !wake_oe)
		else $error("wake not released after a press");
	chk_uv_irq_low: assert property ($rose(undervoltage) |-> ##[1:4] irq_oe)
		else $error("interrupt pin not pulled on undervoltage");
	chk_clear_irq: assert property (reg_wr && reg_addr == OFF_IRQ_CLR && reg_wdata == 8'h1f && !undervoltage && !overtemp && rail_below_pg == 7'h00 |-> ##2 !irq_oe)
		else $error("interrupt pin held after clear");
	chk_alive_reset: assert property (always_alive_low [*4] |-> reset_oe)
		else $error("reset not held while always-alive rail low");
	chk_rail_low_pg: assert property ((rail_enable[0] && rail_below_pg[0]) [*4] |-> power_ok_oe)
		else $error("power ok kept with a low rail");
	chk_all_off_pg: assert property ((rail_enable == 7'h00) [*2] |-> power_ok_oe)
		else $error("power ok kept with all rails off");
	chk_term_ref: assert property (rail_enable[3] |-> termination_reference_enable == TERM_VARIANT)
		else $error("reference output does not follow first buck");
	chk_slave_addr: assert property (slave_address == (TERM_VARIANT ? SLAVE_ADDR_TERM : SLAVE_ADDR_STD))
		else $error("wrong slave address");
endmodule
bind power_pins power_pins_chk #(.ACK_TIMEOUT(ACK_TIMEOUT), .TERM_VARIANT(TERM_VARIANT)) u_chk (.*);
`default_nettype wire

// ---- bench/host_model.sv ----
// Host processor that answers a released wake pin with an acknowledge.
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// Clock
	input wire logic core_clk,
	// Handshake
	input wire logic wake_oe,
	input wire logic ack_allow,
	input wire logic [7:0] ack_delay,
	output logic power_ack_in
);
	logic [7:0] cnt = 8'h00;
	initial power_ack_in = 1'b0;
	// Answers after a chosen delay; a withdrawn permission drops the acknowledge at once.
	always @(posedge core_clk) begin
		if (!ack_allow) begin
			power_ack_in <= 1'b0;
			cnt <= 8'h00;
		end else if (!wake_oe && !power_ack_in) begin
			cnt <= cnt + 8'h01;
			if (cnt == ack_delay) power_ack_in <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking testbench for the power control pin block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import power_pins_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n, clk_en, standby_voltage_select_in, power_ack_in, button_n, any_slewing;
	logic undervoltage, overtemp, always_alive_low, vin_above_uv, serial_port_supply_low;
	logic reg_wr, reg_rd, ack_allow, termination_reference_enable, use_standby_voltage;
	logic power_removed, irq, wake_out, wake_oe, irq_out, irq_oe, reset_out, reset_oe;
	logic power_ok_out, power_ok_oe;
	logic [6:0] en_pins, rail_below_pg, rail_enable, slave_address;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, ack_delay;
	wire ldo_a_enable_in, ldo_b_enable_in, ldo_c_enable_in, buck_one_enable_in;
	wire buck_two_enable_in, buck_three_enable_in, buck_four_enable_in;
	int n_mismatch = 0;
	int tests_run = 0;
	assign {buck_four_enable_in, buck_three_enable_in, buck_two_enable_in} = en_pins[6:4];
	assign {buck_one_enable_in, ldo_c_enable_in, ldo_b_enable_in, ldo_a_enable_in} = en_pins[3:0];
	// Short timeouts keep the handshake and input-threshold runs brief.
	power_pins #(.ACK_TIMEOUT(32'h14), .VIN_TIMEOUT(32'h14)) u_dut (.*);
	host_model u_host (.core_clk(core_clk), .wake_oe(wake_oe), .ack_allow(ack_allow),
		.ack_delay(ack_delay), .power_ack_in(power_ack_in));
	always #2.5 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////////////////////////
	// Waits end 1 ns after the edge so the edge's updates have landed.
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask
	task automatic do_reset();
		rst_n <= 1'b0;
		tick(16);
		rst_n <= 1'b1;
		tick(1);
	endtask
	task automatic press();
		button_n <= 1'b0;
		tick(4);
		button_n <= 1'b1;
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////////////////
	// Defaults after reset, including an unmapped address.
	task automatic check_reset_values();
		rd(OFF_IRQ_EN, 8'h1f);
		rd(OFF_CTRL, 8'h00);
		rd(8'h08, 8'h00);
		rd(OFF_ADDR, 8'h3c);
		check({4'h0, wake_out, irq_out, reset_out, power_ok_out}, 8'h00);
		check(8'(slave_address), 8'h3c);
		check(8'(power_ok_oe), 8'h01);
	endtask
	// Each enable pin alone, then its rail failing, then all off; slewing with and without mask.
	task automatic check_rails();
		for (int k = 0; k < 7; k++) begin
			en_pins <= 7'(1 << k);
			tick(4);
			check(8'(rail_enable), 8'(1 << k));
			check({6'h0, power_ok_oe, termination_reference_enable}, 8'h00);
			rail_below_pg <= 7'(1 << k);
			tick(4);
			check(8'(power_ok_oe), 8'h01);
			{rail_below_pg, en_pins} <= 14'h0;
			tick(4);
			check(8'(power_ok_oe), 8'h01);
		end
		{any_slewing, en_pins} <= 8'h81;
		tick(4);
		check(8'(power_ok_oe), 8'h01);
		wr(OFF_CTRL, 8'h01);
		tick(2);
		check(8'(power_ok_oe), 8'h00);
		{any_slewing, en_pins} <= 8'h00;
		// The software enable turns every rail on with all pins low.
		wr(OFF_CTRL, 8'h04);
		rd(OFF_PINS, 8'h7f);
		wr(OFF_CTRL, 8'h00);
		wr(OFF_IRQ_CLR, 8'h1f);
	endtask
	// Only bit 5 of the run register selects; the pin overrides it.
	task automatic check_standby();
		wr(OFF_RUN_VOLT, 8'h20);
		check(8'(use_standby_voltage), 8'h01);
		wr(OFF_RUN_VOLT, 8'hdf);
		check(8'(use_standby_voltage), 8'h00);
		standby_voltage_select_in <= 1'b1;
		tick(4);
		check(8'(use_standby_voltage), 8'h01);
		standby_voltage_select_in <= 1'b0;
	endtask
	// Raise, clear and mask events.
	task automatic check_irq();
		undervoltage <= 1'b1;
		tick(2);
		undervoltage <= 1'b0;
		tick(4);
		check({6'h0, irq, irq_oe}, 8'h03);
		rd(OFF_STATUS, 8'h02);
		wr(OFF_IRQ_CLR, 8'h1f);
		tick(1);
		check({6'h0, irq, irq_oe}, 8'h00);
		wr(OFF_IRQ_EN, 8'h1b);
		overtemp <= 1'b1;
		tick(2);
		overtemp <= 1'b0;
		tick(4);
		check(8'(irq), 8'h00);
		rd(OFF_STATUS, 8'h04);
		wr(OFF_IRQ_EN, 8'h1f);
		check(8'(irq), 8'h01);
		wr(OFF_IRQ_CLR, 8'h1f);
		rd(OFF_STATUS, 8'h00);
	endtask
	task automatic check_reset_out();
		check(8'(reset_oe), 8'h00);
		// A low clock enable freezes the pin path until it returns.
		{clk_en, always_alive_low} <= 2'h1;
		tick(4);
		check(8'(reset_oe), 8'h00);
		clk_en <= 1'b1;
		tick(4);
		check(8'(reset_oe), 8'h01);
		always_alive_low <= 1'b0;
		wr(OFF_CTRL, 8'h02);
		tick(4);
		check(8'(reset_oe), 8'h01);
		wr(OFF_CTRL, 8'h00);
		tick(4);
		check(8'(reset_oe), 8'h00);
	endtask
	// Prompt and slow host, then a host that never answers.
	task automatic check_wake();
		check(8'(wake_oe), 8'h01);
		for (int k = 0; k < 2; k++) begin
			ack_delay <= k ? 8'h0c : 8'h03;
			ack_allow <= 1'b1;
			press();
			check(8'(wake_oe), 8'h00);
			tick(30);
			check({6'h0, wake_oe, power_removed}, 8'h00);
			ack_allow <= 1'b0;
			tick(4);
			check(8'(wake_oe), 8'h01);
		end
		press();
		for (int k = 0; k < 40 && power_removed !== 1'b1; k++) tick(1);
		check(8'(power_removed), 8'h01);
		rd(OFF_STATUS, 8'h08);
	endtask
	task automatic check_supply_loss();
		wr(OFF_IRQ_EN, 8'h00);
		wr(OFF_RUN_VOLT, 8'h20);
		serial_port_supply_low <= 1'b1;
		tick(4);
		serial_port_supply_low <= 1'b0;
		tick(1);
		rd(OFF_IRQ_EN, 8'h1f);
		rd(OFF_RUN_VOLT, 8'h00);
		rd(OFF_STATUS, 8'h00);
	endtask
	// Input never crosses its threshold after a fresh reset.
	task automatic check_vin_timeout();
		vin_above_uv <= 1'b0;
		do_reset();
		check(8'(power_removed), 8'h00);
		for (int k = 0; k < 60 && power_removed !== 1'b1; k++) tick(1);
		check(8'(power_removed), 8'h01);
		rd(OFF_STATUS, 8'h10);
	endtask
	////////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, standby_voltage_select_in, any_slewing, undervoltage, overtemp} = 5'h0;
		{always_alive_low, serial_port_supply_low, reg_wr, reg_rd, ack_allow} = 5'h0;
		{clk_en, button_n, vin_above_uv} = 3'h7;
		{en_pins, rail_below_pg, reg_addr, reg_wdata, ack_delay} = 38'h0;
		do_reset();
		check_reset_values();
		check_rails();
		check_standby();
		check_irq();
		check_reset_out();
		check_wake();
		check_supply_loss();
		check_vin_timeout();
		print_verdict();
	end
endmodule
`default_nettype wire
